// file: common/sppl_pkg.sv
// sppl_pkg: constants and types shared by the sector protection block
// assumes a 250 MHz core clock and an AXI4-Lite register port with 32-bit data
package sppl_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 4;          // core clock period
  localparam int unsigned UNLOCK_WAIT_NS  = 100000;     // failed unlock lockout, 100 us
  // least wait, rounded up to whole cycles
  localparam int unsigned UNLOCK_WAIT_CYC = (UNLOCK_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // geometry and storage
  // ----------------------------------------------------------------
  localparam int unsigned N_SECT     = 158;             // guarded sectors/blocks
  localparam int unsigned SECT_W     = 8;               // sector index width
  localparam int unsigned PW_W       = 64;              // password width
  localparam int unsigned CFG_W      = 3;               // mode config width
  localparam int unsigned CFG_PWSEL  = 2;               // 0 selects password mode
  localparam logic [2:0]  CFG_BLANK  = 3'h7;            // unprogrammed mode config

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W     = 8;
  localparam logic [7:0]  OFS_CMD    = 8'h00;           // command, write only
  localparam logic [7:0]  OFS_STATUS = 8'h04;           // status flags
  localparam logic [7:0]  OFS_PWLO   = 8'h08;           // password bits 31:0
  localparam logic [7:0]  OFS_PWHI   = 8'h0c;           // password bits 63:32
  localparam logic [7:0]  OFS_CFG    = 8'h10;           // mode config readback
  localparam logic [7:0]  OFS_SECT   = 8'h14;           // selected sector state

  // command word fields
  localparam int unsigned CMD_OP_LSB   = 0;             // opcode 3:0
  localparam int unsigned CMD_VAL_BIT  = 4;             // guard value for volatile write
  localparam int unsigned CMD_SECT_LSB = 8;             // sector index 15:8

  // status bits
  localparam int unsigned ST_BUSY   = 0;
  localparam int unsigned ST_PFAIL  = 1;
  localparam int unsigned ST_PROT   = 2;
  localparam int unsigned ST_FREEZE = 3;
  localparam int unsigned ST_PWMODE = 4;
  localparam int unsigned ST_INIT   = 5;

  // sector state bits
  localparam int unsigned SS_OPEN   = 0;
  localparam int unsigned SS_PG     = 1;
  localparam int unsigned SS_VG     = 2;
  localparam int unsigned SS_IDX    = 8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    CMD_NOP         = 4'h0,
    CMD_WR_VGUARD   = 4'h1,
    CMD_PROG_PGUARD = 4'h2,
    CMD_ERASE_PG    = 4'h3,
    CMD_CLR_FREEZE  = 4'h4,
    CMD_UNLOCK      = 4'h5,
    CMD_PROG_PW     = 4'h6,
    CMD_PROG_CFG    = 4'h7,
    CMD_CHECK_WR    = 4'h8,
    CMD_SOFT_RST    = 4'h9,
    CMD_CLR_FLAGS   = 4'ha
  } sppl_cmd_t;

  typedef enum logic [0:0] {
    UL_IDLE = 1'b0,
    UL_WAIT = 1'b1
  } sppl_ul_t;

endpackage : sppl_pkg

// file: hw/sppl_guard.sv
// sppl_guard: per-sector guard bits, freeze bit and password unlock
// assumes an AXI4-Lite master on core_clk and that nv_blank is pulsed once
// to load the blank non-volatile state before first use
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.

// Summary of operation
// - volatile guard bit per sector, written 0/1
// - volatile bit matters only if persistent bit 1
// - unprotected only when both guard bits 1
// - volatile writes always allowed, ignoring freeze
// - freeze 0 refuses persistent program and erase
// - persistent mode: reset sets freeze, soft keeps
// - clear command drops freeze; persistent never re-sets
// - password mode: reset clears freeze, unlock sets
// - unlock compares all 64 bits exactly
// - mismatch raises failure and violation flags
// - failed unlock busy for 100 us
// - matching unlock ends busy without waiting
// - password blank ones, programming only clears bits
// - password mode selected: password access ignored
// - mode config bits one-time, never erased
// - volatile guards unprotected after any reset
// - persistent bits survive resets, change by command
// - password readback only before password mode
// - persistent bits program singly, erase together
module sppl_guard #(
  parameter int unsigned N_SECT     = sppl_pkg::N_SECT,
  parameter int unsigned UNLOCK_CYC = sppl_pkg::UNLOCK_WAIT_CYC
) (
  // clock, reset, enable
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  // factory blank load of non-volatile state
  input  wire logic        nv_blank,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  localparam int unsigned CW = $clog2(UNLOCK_CYC + 1);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // sector writable only when both guards are 1
  function automatic logic sect_open(input logic pg, input logic vg);
    return pg & vg;
  endfunction : sect_open

  // byte-lane merge for strobed writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic              awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0]        bresp_r, rresp_r;
  logic [31:0]       rdata_r;
  logic              aw_hold_r, w_hold_r;     // captured write halves
  logic [7:0]        awaddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic              cmd_v_r;                 // command pulse
  sppl_pkg::sppl_cmd_t cmd_op_r;
  logic              cmd_val_r;
  logic [7:0]        cmd_sect_r;
  logic [7:0]        sel_sect_r;              // sector shown in state reg
  logic [N_SECT-1:0] vguard_r;                // volatile guards
  logic [N_SECT-1:0] pguard_r;                // persistent guards, no reset
  logic [63:0]       pw_r;                    // hidden password, no reset
  logic [2:0]        cfg_r;                   // mode config, no reset
  logic [63:0]       pw_in_r;                 // supplied password staging
  logic              freeze_r;
  logic              init_pend_r;             // freeze not yet seeded
  logic              pfail_r, prot_r;
  sppl_pkg::sppl_ul_t ul_st_r;
  logic [CW-1:0]     ul_cnt_r;

  logic wr_fire, exec, sect_ok, pw_mode, pw_match, ul_bad, ul_good;
  logic pg_refused, chk_bad, flag_set, flag_clr;
  logic [31:0] rd_mux;
  logic [1:0]  rd_resp, wr_resp;

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  assign wr_fire  = aw_hold_r & w_hold_r & ~bvalid_r;
  // commands during lockout or before freeze seeding are dropped
  assign exec     = cmd_v_r & clk_en & ~init_pend_r & (ul_st_r == sppl_pkg::UL_IDLE);
  assign sect_ok  = 32'(cmd_sect_r) < N_SECT;
  assign pw_mode  = ~cfg_r[sppl_pkg::CFG_PWSEL];
  assign pw_match = (pw_in_r == pw_r);
  assign ul_good  = exec & (cmd_op_r == sppl_pkg::CMD_UNLOCK) & pw_mode & pw_match;
  assign ul_bad   = exec & (cmd_op_r == sppl_pkg::CMD_UNLOCK) & pw_mode & ~pw_match;
  assign pg_refused = exec & ~freeze_r &
                      (cmd_op_r == sppl_pkg::CMD_PROG_PGUARD || cmd_op_r == sppl_pkg::CMD_ERASE_PG);
  assign chk_bad  = exec & (cmd_op_r == sppl_pkg::CMD_CHECK_WR) &
                    (~sect_ok || !sect_open(pguard_r[cmd_sect_r], vguard_r[cmd_sect_r]));
  assign flag_set = ul_bad | pg_refused | chk_bad;
  assign flag_clr = exec & (cmd_op_r == sppl_pkg::CMD_CLR_FLAGS);

  // ----------------------------------------------------------------
  // axi write channel
  // ----------------------------------------------------------------
  // address and data taken in either order, answered one cycle after both
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= sppl_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_awvalid && awready_r) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
        wready_r <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_resp;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // writes to read-only words are dropped quietly, unmapped gets an error
  always_comb begin
    unique case (awaddr_r)
      sppl_pkg::OFS_CMD, sppl_pkg::OFS_STATUS, sppl_pkg::OFS_PWLO,
      sppl_pkg::OFS_PWHI, sppl_pkg::OFS_CFG, sppl_pkg::OFS_SECT: wr_resp = sppl_pkg::RESP_OKAY;
      default: wr_resp = sppl_pkg::RESP_SLVERR;
    endcase
  end

  // command latch and password staging
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_v_r    <= 1'b0;
      cmd_op_r   <= sppl_pkg::CMD_NOP;
      cmd_val_r  <= 1'b0;
      cmd_sect_r <= 8'h00;
      pw_in_r    <= 64'h0000_0000_0000_0000;
    end else if (clk_en) begin
      cmd_v_r <= wr_fire && (awaddr_r == sppl_pkg::OFS_CMD) && wstrb_r[0];
      if (wr_fire && awaddr_r == sppl_pkg::OFS_CMD && wstrb_r[0]) begin
        cmd_op_r   <= sppl_pkg::sppl_cmd_t'(wdata_r[sppl_pkg::CMD_OP_LSB +: 4]);
        cmd_val_r  <= wdata_r[sppl_pkg::CMD_VAL_BIT];
        cmd_sect_r <= wdata_r[sppl_pkg::CMD_SECT_LSB +: 8];
      end
      if (wr_fire && awaddr_r == sppl_pkg::OFS_PWLO) begin
        pw_in_r[31:0] <= merge(pw_in_r[31:0], wdata_r, wstrb_r);
      end
      if (wr_fire && awaddr_r == sppl_pkg::OFS_PWHI) begin
        pw_in_r[63:32] <= merge(pw_in_r[63:32], wdata_r, wstrb_r);
      end
    end
  end

  // ----------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------
  always_comb begin
    rd_mux  = 32'h0000_0000;
    rd_resp = sppl_pkg::RESP_OKAY;
    unique case (s_axi_araddr)
      sppl_pkg::OFS_CMD: rd_mux = 32'h0000_0000;
      sppl_pkg::OFS_STATUS: begin
        rd_mux[sppl_pkg::ST_BUSY]   = (ul_st_r == sppl_pkg::UL_WAIT);
        rd_mux[sppl_pkg::ST_PFAIL]  = pfail_r;
        rd_mux[sppl_pkg::ST_PROT]   = prot_r;
        rd_mux[sppl_pkg::ST_FREEZE] = freeze_r;
        rd_mux[sppl_pkg::ST_PWMODE] = pw_mode;
        rd_mux[sppl_pkg::ST_INIT]   = init_pend_r;
      end
      // password hidden once password mode is chosen
      sppl_pkg::OFS_PWLO: rd_mux = pw_mode ? 32'h0000_0000 : pw_r[31:0];
      sppl_pkg::OFS_PWHI: rd_mux = pw_mode ? 32'h0000_0000 : pw_r[63:32];
      sppl_pkg::OFS_CFG:  rd_mux = {29'h0, cfg_r};
      sppl_pkg::OFS_SECT: begin
        rd_mux[sppl_pkg::SS_IDX +: 8] = sel_sect_r;
        if (32'(sel_sect_r) < N_SECT) begin
          rd_mux[sppl_pkg::SS_OPEN] = sect_open(pguard_r[sel_sect_r], vguard_r[sel_sect_r]);
          rd_mux[sppl_pkg::SS_PG]   = pguard_r[sel_sect_r];
          rd_mux[sppl_pkg::SS_VG]   = vguard_r[sel_sect_r];
        end
      end
      default: rd_resp = sppl_pkg::RESP_SLVERR;
    endcase
  end

  // read answered at the same edge that takes the address
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= sppl_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (s_axi_arvalid && arready_r) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rdata_r   <= rd_mux;
        rresp_r   <= rd_resp;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // volatile guards
  // ----------------------------------------------------------------
  // reset and soft reset both set every volatile guard to 1
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      vguard_r   <= '1;
      sel_sect_r <= 8'h00;
    end else if (clk_en) begin
      if (exec) begin
        sel_sect_r <= cmd_sect_r;
      end
      if (exec && cmd_op_r == sppl_pkg::CMD_SOFT_RST) begin
        vguard_r <= '1;
      end else if (exec && cmd_op_r == sppl_pkg::CMD_WR_VGUARD && sect_ok) begin
        vguard_r[cmd_sect_r] <= cmd_val_r;
      end
    end
  end

  // ----------------------------------------------------------------
  // non-volatile storage: persistent guards, password, mode config
  // ----------------------------------------------------------------
  // no reset here: these model cells that outlive power and resets
  always_ff @(posedge core_clk) begin
    if (clk_en) begin
      if (nv_blank) begin
        pguard_r <= '1;
        pw_r     <= '1;
        cfg_r    <= sppl_pkg::CFG_BLANK;
      end else if (exec && freeze_r) begin
        if (cmd_op_r == sppl_pkg::CMD_PROG_PGUARD && sect_ok) begin
          pguard_r[cmd_sect_r] <= 1'b0;
        end else if (cmd_op_r == sppl_pkg::CMD_ERASE_PG) begin
          pguard_r <= '1;
        end
      end
      // programming only clears bits, a 1 over a 0 is silently kept
      if (!nv_blank && exec && cmd_op_r == sppl_pkg::CMD_PROG_PW && !pw_mode) begin
        pw_r <= pw_r & pw_in_r;
      end
      // one-time bits: an and can only ever clear them
      if (!nv_blank && exec && cmd_op_r == sppl_pkg::CMD_PROG_CFG) begin
        cfg_r <= cfg_r & cmd_sect_r[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // freeze bit
  // ----------------------------------------------------------------
  // seeded from the mode one clock after reset release, since the mode
  // lives in unreset storage and cannot feed the asynchronous reset
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      freeze_r    <= 1'b0;
      init_pend_r <= 1'b1;
    end else if (clk_en) begin
      if (init_pend_r) begin
        freeze_r    <= ~pw_mode;
        init_pend_r <= 1'b0;
      end else if (exec && cmd_op_r == sppl_pkg::CMD_CLR_FREEZE) begin
        freeze_r <= 1'b0;
      end else if (ul_good) begin
        freeze_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // error flags
  // ----------------------------------------------------------------
  // sticky; a new failure in the clear cycle still sets the flag
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pfail_r <= 1'b0;
      prot_r  <= 1'b0;
    end else if (clk_en) begin
      pfail_r <= flag_set | (pfail_r & ~flag_clr);
      prot_r  <= flag_set | (prot_r & ~flag_clr);
    end
  end

  // ----------------------------------------------------------------
  // unlock lockout
  // ----------------------------------------------------------------
  // only a mismatch pays the delay, which rate-limits guessing
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ul_st_r  <= sppl_pkg::UL_IDLE;
      ul_cnt_r <= '0;
    end else if (clk_en) begin
      unique case (ul_st_r)
        sppl_pkg::UL_IDLE: begin
          if (ul_bad) begin
            ul_st_r  <= sppl_pkg::UL_WAIT;
            ul_cnt_r <= CW'(UNLOCK_CYC - 1);
          end
        end
        sppl_pkg::UL_WAIT: begin
          if (ul_cnt_r == '0) begin
            ul_st_r <= sppl_pkg::UL_IDLE;
          end else begin
            ul_cnt_r <= ul_cnt_r - 1'b1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_vg_write;
    @(posedge core_clk) disable iff (sys_rst)
    exec && cmd_op_r == sppl_pkg::CMD_WR_VGUARD && sect_ok |=> vguard_r[$past(cmd_sect_r)] == $past(cmd_val_r);
  endproperty
  a_vg_write: assert property (p_vg_write) else $error("volatile guard not written");

  property p_pg_dominates;
    @(posedge core_clk) disable iff (sys_rst)
    exec && cmd_op_r == sppl_pkg::CMD_CHECK_WR && sect_ok && !pguard_r[cmd_sect_r] |=> prot_r && pfail_r;
  endproperty
  a_pg_dominates: assert property (p_pg_dominates) else $error("persistent guard ignored");

  property p_pg_frozen;
    @(posedge core_clk) disable iff (sys_rst)
    pg_refused && !nv_blank |=> $stable(pguard_r) ##0 prot_r;
  endproperty
  a_pg_frozen: assert property (p_pg_frozen) else $error("persistent guard changed while frozen");

  property p_seed;
    @(posedge core_clk) disable iff (sys_rst)
    init_pend_r && clk_en |=> freeze_r == !$past(pw_mode) && !init_pend_r;
  endproperty
  a_seed: assert property (p_seed) else $error("freeze seeded wrong after reset");

  property p_soft_rst;
    @(posedge core_clk) disable iff (sys_rst)
    exec && cmd_op_r == sppl_pkg::CMD_SOFT_RST |=> (&vguard_r) && freeze_r == $past(freeze_r);
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset handling wrong");

  property p_no_refreeze;
    @(posedge core_clk) disable iff (sys_rst)
    !init_pend_r && !freeze_r && !pw_mode |=> !freeze_r;
  endproperty
  a_no_refreeze: assert property (p_no_refreeze) else $error("freeze rose in persistent mode");

  property p_bad_pw;
    @(posedge core_clk) disable iff (sys_rst)
    ul_bad && !freeze_r |=> !freeze_r && pfail_r && prot_r && ul_st_r == sppl_pkg::UL_WAIT;
  endproperty
  a_bad_pw: assert property (p_bad_pw) else $error("mismatch not flagged");

  property p_lockout;
    @(posedge core_clk) disable iff (sys_rst)
    ul_st_r == sppl_pkg::UL_WAIT && ul_cnt_r != '0 |=> ul_st_r == sppl_pkg::UL_WAIT;
  endproperty
  a_lockout: assert property (p_lockout) else $error("lockout ended early");

  property p_good_pw;
    @(posedge core_clk) disable iff (sys_rst)
    ul_good |=> freeze_r && ul_st_r == sppl_pkg::UL_IDLE;
  endproperty
  a_good_pw: assert property (p_good_pw) else $error("match did not unlock at once");

  property p_pw_bits;
    @(posedge core_clk) disable iff (sys_rst)
    !nv_blank |=> (pw_r & ~$past(pw_r)) == '0 && (cfg_r & ~$past(cfg_r)) == '0;
  endproperty
  a_pw_bits: assert property (p_pw_bits) else $error("one-time bit went back to 1");

  property p_erase_all;
    @(posedge core_clk) disable iff (sys_rst)
    exec && freeze_r && cmd_op_r == sppl_pkg::CMD_ERASE_PG |=> &pguard_r;
  endproperty
  a_erase_all: assert property (p_erase_all) else $error("persistent erase incomplete");

endmodule : sppl_guard

// file: testbench/sppl_host.sv
// sppl_host: axi4-lite master standing in for the flash controller
// assumes a free running core_clk; the bench calls wr and rd in turn
module sppl_host (
  // clock
  input  wire logic        core_clk,
  // write channels
  output logic [7:0]       s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // read channels
  output logic [7:0]       s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // both write channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  // rready held from the start, data taken at the rvalid edge
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge core_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : sppl_host

// file: testbench/sppl_guard_bench.sv
// sppl_guard_bench: self-checking bench for the sector guard block
// assumes sppl_host as the only bus master and a short unlock lockout
module sppl_guard_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned UL = 16; // short lockout keeps the run brief
  localparam logic [7:0] ST = sppl_pkg::OFS_STATUS, SC = sppl_pkg::OFS_SECT;
  logic core_clk, sys_rst, nv_blank, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [3:0]  s_axi_wstrb = 4'hf; // whole words only
  logic        clk_en = 1'b1;
  int          error_cnt = 0, samples_checked = 0, cyc = 0, t0;
  sppl_guard #(.N_SECT(sppl_pkg::N_SECT), .UNLOCK_CYC(UL)) DUT (.core_clk, .sys_rst, .clk_en,
    .nv_blank, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  sppl_host host (.core_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // 250 MHz clock and a cycle count for lockout timing
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= cyc + 1;
  // tests need about 270 cycles; 5000 cycles, some eighteen times that, marks a hang
  initial begin
    #20000;
    error_cnt++;
    $display("FAIL t=%0t watchdog", $time);
    report_and_stop();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    chk({30'h0, got}, {30'h0, exp});
  endtask : chk_resp
  task automatic cmd(input sppl_pkg::sppl_cmd_t op, input logic [7:0] s, input logic v);
    host.wr(sppl_pkg::OFS_CMD, {16'h0, s, 3'h0, v, op}, r);
    chk_resp(r, sppl_pkg::RESP_OKAY);
  endtask : cmd
  task automatic expect_rd(input logic [7:0] a, input logic [31:0] e);
    host.rd(a, d, r);
    chk(d, e);
  endtask : expect_rd
  task automatic stage(input logic [31:0] hi, input logic [31:0] lo);
    host.wr(sppl_pkg::OFS_PWHI, hi, r);
    host.wr(sppl_pkg::OFS_PWLO, lo, r);
  endtask : stage
  // hardware reset held for 16 cycles, then seeding settles
  task automatic hw_reset();
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : hw_reset
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  // main sequence: guards, freeze, password, unlock, bus errors
  initial begin
    sys_rst = 1'b1;
    nv_blank = 1'b1;
    hw_reset();
    nv_blank <= 1'b0;
    expect_rd(ST, 32'h08);
    cmd(sppl_pkg::CMD_WR_VGUARD, 8'h05, 1'b0);
    expect_rd(SC, 32'h0502);
    cmd(sppl_pkg::CMD_WR_VGUARD, 8'h05, 1'b1);
    expect_rd(SC, 32'h0507);
    cmd(sppl_pkg::CMD_PROG_PGUARD, 8'h05, 1'b0);
    expect_rd(SC, 32'h0504);
    cmd(sppl_pkg::CMD_CHECK_WR, 8'h05, 1'b0);
    expect_rd(ST, 32'h0e);
    cmd(sppl_pkg::CMD_CLR_FLAGS, 8'h00, 1'b0);
    cmd(sppl_pkg::CMD_ERASE_PG, 8'h00, 1'b0);
    cmd(sppl_pkg::CMD_CHECK_WR, 8'h05, 1'b0);
    expect_rd(ST, 32'h08);
    expect_rd(SC, 32'h0507);
    $display("test guards done");
    cmd(sppl_pkg::CMD_CLR_FREEZE, 8'h00, 1'b0);
    expect_rd(ST, 32'h00);
    cmd(sppl_pkg::CMD_PROG_PGUARD, 8'h06, 1'b0);
    cmd(sppl_pkg::CMD_WR_VGUARD, 8'h06, 1'b0);
    expect_rd(ST, 32'h06);
    expect_rd(SC, 32'h0602);
    cmd(sppl_pkg::CMD_SOFT_RST, 8'h00, 1'b0);
    cmd(sppl_pkg::CMD_CHECK_WR, 8'h06, 1'b0);
    expect_rd(ST, 32'h06);
    expect_rd(SC, 32'h0607);
    $display("test freeze done");
    cmd(sppl_pkg::CMD_CLR_FLAGS, 8'h00, 1'b0);
    stage(32'h9abcdef0, 32'h12345678);
    cmd(sppl_pkg::CMD_PROG_PW, 8'h00, 1'b0);
    stage(32'hffffffff, 32'hffffffff);
    cmd(sppl_pkg::CMD_PROG_PW, 8'h00, 1'b0);
    expect_rd(sppl_pkg::OFS_PWLO, 32'h12345678);
    expect_rd(ST, 32'h00);
    cmd(sppl_pkg::CMD_PROG_CFG, 8'h03, 1'b0);
    cmd(sppl_pkg::CMD_PROG_CFG, 8'h07, 1'b0);
    expect_rd(sppl_pkg::OFS_CFG, 32'h3);
    expect_rd(sppl_pkg::OFS_PWHI, 32'h0);
    stage(32'h0, 32'h0);
    cmd(sppl_pkg::CMD_PROG_PW, 8'h00, 1'b0);
    hw_reset();
    expect_rd(ST, 32'h10);
    $display("test password done");
    stage(32'h1abcdef0, 32'h12345678);
    cmd(sppl_pkg::CMD_UNLOCK, 8'h00, 1'b0);
    t0 = cyc;
    host.wr(sppl_pkg::OFS_PWHI, 32'h9abcdef0, r);
    cmd(sppl_pkg::CMD_UNLOCK, 8'h00, 1'b0);
    expect_rd(ST, 32'h17);
    for (int i = 0; i < 20 && d[0] !== 1'b0; i++) host.rd(ST, d, r);
    chk(d, 32'h16);
    chk({31'h0, (cyc - t0) >= UL}, 32'h1);
    cmd(sppl_pkg::CMD_CLR_FLAGS, 8'h00, 1'b0);
    cmd(sppl_pkg::CMD_UNLOCK, 8'h00, 1'b0);
    expect_rd(ST, 32'h18);
    cmd(sppl_pkg::CMD_PROG_PGUARD, 8'h06, 1'b0);
    hw_reset();
    cmd(sppl_pkg::CMD_CHECK_WR, 8'h06, 1'b0);
    expect_rd(ST, 32'h16);
    expect_rd(SC, 32'h0604);
    $display("test unlock done");
    host.wr(8'h20, 32'h0, r);
    chk_resp(r, sppl_pkg::RESP_SLVERR);
    host.rd(8'h20, d, r);
    chk_resp(r, sppl_pkg::RESP_SLVERR);
    $display("test bus done");
    report_and_stop();
  end
endmodule : sppl_guard_bench
